// ---- verilog/lsi_led_status.sv ----
// maps device and per-channel state onto supply and traffic indicators
// assumes every status input is already synchronous to MCLK (firmware
// registers and on-chip CAN controllers), so none is resynchronised
`timescale 1ns/1ps

// What this block does
// - one supply, one traffic dual-colour per channel
// - device faults show same pattern on all
// - flash is brief pulse per event
// - slow blink has equal lit and dark
// - fast blink 50 percent, faster than slow
// - waver alternates colours, slow and fast
// - running lights each colour in order
// - normal interface mode: supply steady green
// - unconfigured: supply slow yellow, traffic dark
// - low supply: waver supply, blink traffic yellow
// - idle channel traffic indicator dark
// - message flashes yellow, error frame red
// - firmware update: traffic fast blink yellow
// - error passive: fast blink red
// - overrun steady red until bus off
// - tool session: running on all indicators
// - disk activity: green, traffic fast yellow
// - logger hw and battery faults waver supply and traffic
// - disk full/error: yellow, slow red
// - config or script fault: yellow, fast red
// - logger armed, active, stopped on green
// - script state never shown by default
module lsi_led_status #(
  parameter int unsigned CH        = lsi_pkg::CHANNELS,
  parameter int unsigned FLASH_CYC = lsi_pkg::FLASH_CYC,
  parameter int unsigned SLOW_HALF = lsi_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = lsi_pkg::FAST_HALF_CYC,
  parameter int unsigned RUN_STEP  = lsi_pkg::RUN_STEP_CYC
) (
  input  wire logic          MCLK,
  input  wire logic          RESET_N,
  input  wire logic          LOGGER_MODE,
  input  wire logic          USB_CONFIGURED,
  input  wire logic          LOW_SUPPLY,
  input  wire logic          FW_CONFIG_ERROR,
  input  wire logic          FW_UPDATE,
  input  wire logic          TOOL_SESSION,
  input  wire logic          DISK_ACTIVE,
  input  wire logic          LOG_FW_HW_ERROR,
  input  wire logic          LOG_BATTERY_FAULT,
  input  wire logic          LOG_DISK_FAULT,
  input  wire logic          LOG_CONFIG_FAULT,
  input  wire logic          LOG_ARMED,
  input  wire logic          LOG_ACTIVE,
  input  wire logic          LOG_STOPPED,
  input  wire logic [CH-1:0] CH_MSG,
  input  wire logic [CH-1:0] CH_ERR_FRAME,
  input  wire logic [CH-1:0] CH_ERR_PASSIVE,
  input  wire logic [CH-1:0] CH_OVERRUN,
  input  wire logic [CH-1:0] CH_BUS_OFF,
  output logic               SUPPLY_GREEN,
  output logic               SUPPLY_YELLOW,
  output logic      [CH-1:0] TRAFFIC_YELLOW,
  output logic      [CH-1:0] TRAFFIC_RED
);

  localparam int unsigned RUN_LEN = 2 + 2 * CH;  // colours in sequence
  localparam int unsigned RUN_W   = $clog2(RUN_LEN);
  localparam int unsigned FLASH_W = $clog2(FLASH_CYC + 1);

  // refuse settings the pattern logic cannot honour, at elaboration
  if (CH < 1 || FLASH_CYC < 1 || FAST_HALF < 1 ||
      FAST_HALF >= SLOW_HALF || RUN_STEP < 1) begin : g_bad_setting
    $error("lsi_led_status: bad channel count or pattern timing");
  end

  //////////////////////////////////////////////////////////////////////////
  // shared phases
  lsi_tick_if tick ();

  lsi_timebase #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF),
                 .RUN_STEP(RUN_STEP))
    u_timebase (.clk(MCLK), .rst_n(RESET_N), .tick(tick));
  // renders a pattern onto the two colours, result is {second, first}
  function automatic logic [1:0] render(input lsi_pkg::lsi_pat_t pat,
                                        input logic col,
                                        input logic slow,
                                        input logic fast,
                                        input logic flash);
    logic [1:0] r;
    r = 2'b00;
    case (pat)
      lsi_pkg::PAT_ON:         r[col] = 1'b1;
      lsi_pkg::PAT_FLASH:      r[col] = flash;
      lsi_pkg::PAT_SLOW_BLINK: r[col] = slow;
      lsi_pkg::PAT_FAST_BLINK: r[col] = fast;
      lsi_pkg::PAT_SLOW_WAVER: r = slow ? 2'b01 : 2'b10;
      lsi_pkg::PAT_FAST_WAVER: r = fast ? 2'b01 : 2'b10;
      default:                 r = 2'b00;                     // off, running
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // running sequence position
  logic [RUN_W-1:0] run_idx;  // 0 supply green, 1 supply yellow, then ch
  // step through every colour, restart when there is no tool session or in logger mode
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      run_idx <= '0;
    end else if (!TOOL_SESSION || LOGGER_MODE) begin
      run_idx <= '0;  // each session starts on supply green
    end else if (tick.step) begin
      run_idx <= (run_idx == RUN_W'(RUN_LEN - 1)) ? '0
                                                  : run_idx + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // device-wide selection, highest priority first
  lsi_pkg::lsi_pat_t sup_pat;   // supply pattern
  logic              sup_col;   // supply colour
  logic              glob_en;   // one pattern forced on every channel
  lsi_pkg::lsi_pat_t glob_pat;  // that pattern
  logic              glob_col;  // and its colour
  always_comb begin
    sup_pat  = lsi_pkg::PAT_ON;
    sup_col  = lsi_pkg::COL_FIRST;
    glob_en  = 1'b0;
    glob_pat = lsi_pkg::PAT_OFF;
    glob_col = lsi_pkg::COL_FIRST;
    if (LOGGER_MODE) begin
      if (LOG_FW_HW_ERROR) begin
        sup_pat  = lsi_pkg::PAT_FAST_WAVER;
        glob_en  = 1'b1;
        glob_pat = lsi_pkg::PAT_FAST_WAVER;
      end else if (LOG_BATTERY_FAULT) begin
        sup_pat  = lsi_pkg::PAT_FAST_WAVER;
        glob_en  = 1'b1;
        glob_pat = lsi_pkg::PAT_SLOW_WAVER;
      end else if (LOG_DISK_FAULT) begin
        sup_col  = lsi_pkg::COL_SECOND;
        glob_en  = 1'b1;
        glob_pat = lsi_pkg::PAT_SLOW_BLINK;
        glob_col = lsi_pkg::COL_SECOND;
      end else if (LOG_CONFIG_FAULT) begin
        sup_col  = lsi_pkg::COL_SECOND;
        glob_en  = 1'b1;
        glob_pat = lsi_pkg::PAT_FAST_BLINK;
        glob_col = lsi_pkg::COL_SECOND;
      end else if (LOG_ACTIVE) begin
        sup_pat  = lsi_pkg::PAT_FAST_BLINK;
      end else if (LOG_STOPPED) begin
        sup_pat  = lsi_pkg::PAT_SLOW_BLINK;
      end else if (LOG_ARMED) begin
        sup_pat  = lsi_pkg::PAT_ON;
      end else begin
        sup_pat  = lsi_pkg::PAT_OFF;  // no logger state yet
      end
    end else if (TOOL_SESSION && !DISK_ACTIVE) begin
      sup_pat  = lsi_pkg::PAT_RUNNING;
      glob_en  = 1'b1;
      glob_pat = lsi_pkg::PAT_RUNNING;
    end else if (DISK_ACTIVE || FW_UPDATE) begin
      glob_en  = 1'b1;
      glob_pat = lsi_pkg::PAT_FAST_BLINK;
    end else if (!USB_CONFIGURED) begin
      sup_pat  = lsi_pkg::PAT_SLOW_BLINK;
      sup_col  = lsi_pkg::COL_SECOND;
      glob_en  = 1'b1;
      glob_pat = lsi_pkg::PAT_OFF;
    end else if (FW_CONFIG_ERROR) begin
      sup_pat  = lsi_pkg::PAT_SLOW_WAVER;
      glob_en  = 1'b1;
      glob_pat = lsi_pkg::PAT_SLOW_WAVER;
    end else if (LOW_SUPPLY) begin
      sup_pat  = lsi_pkg::PAT_SLOW_WAVER;
      glob_en  = 1'b1;
      glob_pat = lsi_pkg::PAT_SLOW_BLINK;
    end
    // otherwise steady green with per-channel status
  end

  //////////////////////////////////////////////////////////////////////////
  // supply indicator output register
  logic [1:0] sup_lit;  // {yellow, green}
  assign sup_lit = (sup_pat == lsi_pkg::PAT_RUNNING)
                 ? {run_idx == RUN_W'(1), run_idx == RUN_W'(0)}
                 : render(sup_pat, sup_col, tick.slow_ph, tick.fast_ph, 1'b0);

  // registered so the pins never glitch between patterns
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SUPPLY_GREEN  <= lsi_pkg::RST_LED;
      SUPPLY_YELLOW <= lsi_pkg::RST_LED;
    end else begin
      SUPPLY_GREEN  <= sup_lit[0];
      SUPPLY_YELLOW <= sup_lit[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-channel status: flash stretchers, overrun latch, output
  logic [FLASH_W-1:0] fy_cnt [CH];  // yellow flash time left
  logic [FLASH_W-1:0] fr_cnt [CH];  // red flash time left
  logic [CH-1:0]      ovr;          // overrun seen, cleared by bus off
  for (genvar i = 0; i < CH; i++) begin : g_ch
    lsi_pkg::lsi_pat_t ch_pat;  // channel's own pattern
    logic              ch_col;
    logic [1:0]        ch_lit;  // {red, yellow}
    // each event reloads its own pulse, so a stream looks steady
    always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
        fy_cnt[i] <= '0;
        fr_cnt[i] <= '0;
      end else begin
        if (CH_MSG[i]) fy_cnt[i] <= FLASH_W'(FLASH_CYC);
        else if (fy_cnt[i] != '0) fy_cnt[i] <= fy_cnt[i] - 1'b1;
        if (CH_ERR_FRAME[i]) fr_cnt[i] <= FLASH_W'(FLASH_CYC);
        else if (fr_cnt[i] != '0) fr_cnt[i] <= fr_cnt[i] - 1'b1;
      end
    end

    // a new overrun in the bus-off cycle wins over the clear
    always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
        ovr[i] <= 1'b0;
      end else if (CH_OVERRUN[i]) begin
        ovr[i] <= 1'b1;
      end else if (CH_BUS_OFF[i]) begin
        ovr[i] <= 1'b0;
      end
    end
    // channel priority: overrun, passive, error flash, message flash
    always_comb begin
      ch_col = lsi_pkg::COL_SECOND;
      if (ovr[i]) begin
        ch_pat = lsi_pkg::PAT_ON;
      end else if (CH_ERR_PASSIVE[i]) begin
        ch_pat = lsi_pkg::PAT_FAST_BLINK;
      end else if (fr_cnt[i] != '0) begin
        ch_pat = lsi_pkg::PAT_FLASH;
      end else if (fy_cnt[i] != '0) begin
        ch_pat = lsi_pkg::PAT_FLASH;
        ch_col = lsi_pkg::COL_FIRST;
      end else begin
        ch_pat = lsi_pkg::PAT_OFF;
      end
      // device-wide patterns mask the channel's own status
      if (glob_en && glob_pat == lsi_pkg::PAT_RUNNING) begin
        ch_lit = {run_idx == RUN_W'(3 + 2 * i),
                  run_idx == RUN_W'(2 + 2 * i)};
      end else if (glob_en) begin
        ch_lit = render(glob_pat, glob_col, tick.slow_ph, tick.fast_ph,
                        1'b0);
      end else begin
        ch_lit = render(ch_pat, ch_col, tick.slow_ph, tick.fast_ph, 1'b1);
      end
    end
    // registered pins; no script input can reach them
    always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
        TRAFFIC_YELLOW[i] <= lsi_pkg::RST_LED;
        TRAFFIC_RED[i]    <= lsi_pkg::RST_LED;
      end else begin
        TRAFFIC_YELLOW[i] <= ch_lit[0];
        TRAFFIC_RED[i]    <= ch_lit[1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_one_colour;
    @(posedge MCLK) disable iff (!RESET_N)
      !(SUPPLY_GREEN && SUPPLY_YELLOW) && !(|(TRAFFIC_YELLOW & TRAFFIC_RED));
  endproperty
  a_one_colour: assert property (p_one_colour)
    else $error("an indicator lit in both colours");
  property p_global_same;
    @(posedge MCLK) disable iff (!RESET_N)
      (glob_en && glob_pat != lsi_pkg::PAT_RUNNING) |=>
        (TRAFFIC_RED == {CH{TRAFFIC_RED[0]}}) &&
        (TRAFFIC_YELLOW == {CH{TRAFFIC_YELLOW[0]}});
  endproperty
  a_global_same: assert property (p_global_same)
    else $error("device-wide pattern differs between channels");
  property p_flash_load;
    @(posedge MCLK) disable iff (!RESET_N)
      CH_MSG[0] |=> fy_cnt[0] == FLASH_W'(FLASH_CYC) ##1
                    fy_cnt[0] >= FLASH_W'(FLASH_CYC - 1);
  endproperty
  a_flash_load: assert property (p_flash_load)
    else $error("message flash not started at full length");
  property p_normal_green;
    @(posedge MCLK) disable iff (!RESET_N)
      (!LOGGER_MODE && USB_CONFIGURED && !TOOL_SESSION && !DISK_ACTIVE &&
       !FW_UPDATE && !FW_CONFIG_ERROR && !LOW_SUPPLY) |=>
        SUPPLY_GREEN && !SUPPLY_YELLOW;
  endproperty
  a_normal_green: assert property (p_normal_green)
    else $error("supply not steady green in normal interface mode");
  property p_unconfigured;
    @(posedge MCLK) disable iff (!RESET_N)
      (!LOGGER_MODE && !USB_CONFIGURED && !TOOL_SESSION && !DISK_ACTIVE &&
       !FW_UPDATE) |=> TRAFFIC_YELLOW == '0 && TRAFFIC_RED == '0 &&
                       !SUPPLY_GREEN;
  endproperty
  a_unconfigured: assert property (p_unconfigured)
    else $error("traffic lit or supply green before configuration");
  property p_overrun_red;
    @(posedge MCLK) disable iff (!RESET_N)
      (ovr[0] && !glob_en) |=> TRAFFIC_RED[0] && !TRAFFIC_YELLOW[0];
  endproperty
  a_overrun_red: assert property (p_overrun_red)
    else $error("overrun channel not steady red");
  property p_overrun_hold;
    @(posedge MCLK) disable iff (!RESET_N)
      (ovr[0] && !CH_BUS_OFF[0]) |=> ovr[0];
  endproperty
  a_overrun_hold: assert property (p_overrun_hold)
    else $error("overrun indication dropped before bus off");
  property p_running_one;
    @(posedge MCLK) disable iff (!RESET_N)
      (TOOL_SESSION && !LOGGER_MODE && !DISK_ACTIVE)[*2] |=>
        $onehot({SUPPLY_GREEN, SUPPLY_YELLOW, TRAFFIC_YELLOW, TRAFFIC_RED});
  endproperty
  a_running_one: assert property (p_running_one)
    else $error("running pattern lit other than one colour");
  property p_logger_armed;
    @(posedge MCLK) disable iff (!RESET_N)
      (LOGGER_MODE && LOG_ARMED && !LOG_ACTIVE && !LOG_STOPPED &&
       !LOG_FW_HW_ERROR && !LOG_BATTERY_FAULT && !LOG_DISK_FAULT &&
       !LOG_CONFIG_FAULT) |=> SUPPLY_GREEN && !SUPPLY_YELLOW;
  endproperty
  a_logger_armed: assert property (p_logger_armed)
    else $error("armed logger without steady green supply");

endmodule // lsi_led_status

// ---- verilog/lsi_pkg.sv ----
// constants and types shared by the indicator pattern generator
// assumes a single 40 MHz system clock feeding every pattern counter
package lsi_pkg;

  //////////////////////////////////////////////////////////////////////////
  // clock and channel count
  localparam int CLK_HZ        = 40_000_000;  // system clock rate
  localparam int CLK_PER_MS    = CLK_HZ / 1000;
  localparam int CHANNELS      = 5;           // traffic indicators

  //////////////////////////////////////////////////////////////////////////
  // pattern timing, in milliseconds, then in clock cycles
  localparam int FLASH_MS      = 20;   // visible pulse per traffic event
  localparam int SLOW_HALF_MS  = 500;  // slow blink / waver half period
  localparam int FAST_HALF_MS  = 125;  // fast blink / waver half period
  localparam int RUN_STEP_MS   = 150;  // dwell of one running step
  localparam int FLASH_CYC     = FLASH_MS * CLK_PER_MS;
  localparam int SLOW_HALF_CYC = SLOW_HALF_MS * CLK_PER_MS;
  localparam int FAST_HALF_CYC = FAST_HALF_MS * CLK_PER_MS;
  localparam int RUN_STEP_CYC  = RUN_STEP_MS * CLK_PER_MS;

  //////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic RST_LED     = 1'b0;  // every indicator dark
  localparam logic RST_PHASE   = 1'b0;  // blink phases start dark

  //////////////////////////////////////////////////////////////////////////
  // colour index of a dual-colour indicator
  localparam logic COL_FIRST   = 1'b0;  // green (supply) / yellow (traffic)
  localparam logic COL_SECOND  = 1'b1;  // yellow (supply) / red (traffic)

  // indicator patterns, one-hot
  typedef enum logic [7:0] {
    PAT_OFF        = 8'h01,
    PAT_ON         = 8'h02,
    PAT_FLASH      = 8'h04,
    PAT_SLOW_BLINK = 8'h08,
    PAT_FAST_BLINK = 8'h10,
    PAT_SLOW_WAVER = 8'h20,
    PAT_FAST_WAVER = 8'h40,
    PAT_RUNNING    = 8'h80
  } lsi_pat_t;

endpackage

// ---- verilog/lsi_tick_if.sv ----
// carrier for the shared blink phases and running step strobe
// assumes the timebase drives it and the pattern mapper only reads it
`timescale 1ns/1ps
interface lsi_tick_if;
  logic slow_ph;  // slow blink phase, high = lit / first colour
  logic fast_ph;  // fast blink phase
  logic step;     // one-cycle pulse, advance running sequence
  modport src (output slow_ph, output fast_ph, output step);
  modport snk (input  slow_ph, input  fast_ph, input  step);
endinterface

// ---- verilog/lsi_timebase.sv ----
// free-running phase generator for blink, waver and running patterns
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module lsi_timebase #(
  parameter int unsigned SLOW_HALF = lsi_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = lsi_pkg::FAST_HALF_CYC,
  parameter int unsigned RUN_STEP  = lsi_pkg::RUN_STEP_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  lsi_tick_if.src   tick
);

  // one counter per rate; shared by all indicators so they stay in step
  logic [31:0] slow_cnt;
  logic [31:0] fast_cnt;
  logic [31:0] step_cnt;

  //////////////////////////////////////////////////////////////////////////
  // slow phase: equal lit and dark halves
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt     <= '0;
      tick.slow_ph <= lsi_pkg::RST_PHASE;
    end else if (slow_cnt == SLOW_HALF - 1) begin
      slow_cnt     <= '0;
      tick.slow_ph <= !tick.slow_ph;
    end else begin
      slow_cnt     <= slow_cnt + 32'h0000_0001;
    end
  end

  // fast phase: same 50 percent duty, shorter half period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_cnt     <= '0;
      tick.fast_ph <= lsi_pkg::RST_PHASE;
    end else if (fast_cnt == FAST_HALF - 1) begin
      fast_cnt     <= '0;
      tick.fast_ph <= !tick.fast_ph;
    end else begin
      fast_cnt     <= fast_cnt + 32'h0000_0001;
    end
  end

  // running step strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt  <= '0;
      tick.step <= 1'b0;
    end else begin
      tick.step <= (step_cnt == RUN_STEP - 1);
      step_cnt  <= (step_cnt == RUN_STEP - 1) ? '0
                                              : step_cnt + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_slow_half;
    @(posedge clk) disable iff (!rst_n)
      $changed(tick.slow_ph) |-> $past(slow_cnt) == SLOW_HALF - 1;
  endproperty
  a_slow_half: assert property (p_slow_half)
    else $error("slow phase toggled off its half period");

  property p_fast_half;
    @(posedge clk) disable iff (!rst_n)
      $changed(tick.fast_ph) |-> $past(fast_cnt) == FAST_HALF - 1;
  endproperty
  a_fast_half: assert property (p_fast_half)
    else $error("fast phase toggled off its half period");

endmodule // lsi_timebase

// ---- verif/lsi_lamp_model.sv ----
// model of the dual-colour lamps as a user sees them
// assumes lamp drives are active high; looked at on the falling edge
`timescale 1ns/1ps
module lsi_lamp_model #(
  parameter int CH = 2  // traffic lamps
) (
  input  wire logic          clk,
  input  wire logic          sup_green,
  input  wire logic          sup_yellow,
  input  wire logic [CH-1:0] trf_yellow,
  input  wire logic [CH-1:0] trf_red,
  output int                 mixed
);
  //////////////////////////////////////////////////////////////////////////
  // one lamp per indicator shows one colour, so both lit is a muddy mix
  initial mixed = 0;
  // falling edge: registered drives have settled by then
  always @(negedge clk) begin
    if ((sup_green === 1'b1 && sup_yellow === 1'b1) ||
        (trf_yellow & trf_red) !== '0) begin
      mixed <= mixed + 1;
    end
  end
endmodule  // lsi_lamp_model

// ---- verif/led_status_indicator_bench.sv ----
// self-checking bench for the indicator pattern generator
// assumes shortened pattern counts and two traffic channels
`timescale 1ns/1ps
module led_status_indicator_bench;
  localparam int CH = 2;  // fewer channels keep the running loop short
  localparam int NL = 2 * CH + 2;  // lamps in all
  logic            MCLK, RESET_N;
  logic [15:0]     ctl;  // device-wide status levels
  logic [CH-1:0]   msg, efr, epas, ovr, boff;  // per channel status
  wire  [CH-1:0]   ty, tr;  // traffic lamps
  wire             sg, sy;  // supply lamps
  wire  [NL-1:0]   lamps = {tr, ty, sy, sg};
  int              mismatches = 0;
  int              n_checks = 0;
  int              cyc = 0;  // timeout counter
  int              mixed;  // mixed colours seen by the model
  logic [31:0]     code [NL];  // pattern codes: 0 dark, 1 on, else half
  lsi_led_status #(.CH(CH), .FLASH_CYC(4), .SLOW_HALF(16), .FAST_HALF(8),
    .RUN_STEP(6)) dut (.MCLK(MCLK), .RESET_N(RESET_N),
    .LOGGER_MODE(ctl[15]), .USB_CONFIGURED(ctl[14]), .LOW_SUPPLY(ctl[13]),
    .FW_CONFIG_ERROR(ctl[12]), .FW_UPDATE(ctl[11]),
    .TOOL_SESSION(ctl[10]), .DISK_ACTIVE(ctl[9]),
    .LOG_FW_HW_ERROR(ctl[8]), .LOG_BATTERY_FAULT(ctl[7]),
    .LOG_DISK_FAULT(ctl[6]), .LOG_CONFIG_FAULT(ctl[5]),
    .LOG_ARMED(ctl[4]), .LOG_ACTIVE(ctl[3]), .LOG_STOPPED(ctl[2]),
    .CH_MSG(msg), .CH_ERR_FRAME(efr), .CH_ERR_PASSIVE(epas),
    .CH_OVERRUN(ovr), .CH_BUS_OFF(boff), .SUPPLY_GREEN(sg),
    .SUPPLY_YELLOW(sy), .TRAFFIC_YELLOW(ty), .TRAFFIC_RED(tr));
  lsi_lamp_model #(.CH(CH)) lamp (.clk(MCLK), .sup_green(sg),
    .sup_yellow(sy), .trf_yellow(ty), .trf_red(tr), .mixed(mixed));
  //////////////////////////////////////////////////////////////////////////
  // clock and hang guard; ceiling is well above the planned run
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic complete_run();
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // watch every lamp 80 cycles; blink code is the half period only
  // when lit and dark runs match, so uneven duty shows up as 99
  task automatic observe();
    logic [NL-1:0] prev;
    int last [NL], on_n [NL], lit [NL], dark [NL];
    foreach (last[k]) begin
      last[k] = 0; on_n[k] = 0; lit[k] = 0; dark[k] = 0;
    end
    prev = lamps;
    for (int t = 1; t <= 80; t++) begin
      @(negedge MCLK);
      foreach (last[k]) begin
        if (lamps[k] === 1'b1) on_n[k]++;
        if (lamps[k] !== prev[k]) begin
          if (last[k] > 0 && prev[k]) lit[k] = t - last[k];
          else if (last[k] > 0) dark[k] = t - last[k];
          last[k] = t;
        end
      end
      prev = lamps;
    end
    foreach (code[k]) code[k] = (on_n[k] == 0) ? 0 : (on_n[k] == 80) ? 1 :
      (lit[k] == dark[k]) ? lit[k] : 99;
  endtask
  task automatic run_case(input logic [15:0] c,
                          input logic [31:0] g, y, ry, rr);
    ctl = c;
    repeat (3) @(negedge MCLK);
    observe();
    check("supply green", g, code[0]);
    check("supply yellow", y, code[1]);
    for (int i = 0; i < CH; i++) begin
      check("traffic yellow", ry, code[2 + i]);
      check("traffic red", rr, code[2 + CH + i]);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic flash_events();
    int ny = 0, nr = 0;
    ctl = 16'h4000;
    repeat (3) @(negedge MCLK);
    msg = 2'b01;
    efr = 2'b10;
    @(negedge MCLK);
    msg = '0;
    efr = '0;
    repeat (12) begin
      @(negedge MCLK);
      if (ty[0] === 1'b1) ny++;
      if (tr[1] === 1'b1) nr++;
    end
    check("flash yellow", 4, ny);
    check("flash red", 4, nr);
  endtask
  task automatic passive_channel();
    epas = 2'b10;  // only channel 1 error passive, channel 0 quiet
    ctl = 16'h4000;
    repeat (3) @(negedge MCLK);
    observe();
    check("supply green", 1, code[0]);
    check("supply yellow", 0, code[1]);
    for (int i = 2; i < 2 + CH; i++) begin
      check("traffic yellow", 0, code[i]);
    end
    check("quiet red", 0, code[2 + CH]);
    check("passive red", 8, code[3 + CH]);
    run_case(16'h4800, 1, 0, 8, 0);
    epas = '0;
  endtask
  task automatic overrun_hold();
    ctl = 16'h4000;
    ovr = 2'b01;
    @(negedge MCLK);
    ovr = '0;
    repeat (40) @(negedge MCLK);
    check("overrun red", 1, tr[0]);
    boff = 2'b01;
    @(negedge MCLK);
    boff = '0;
    repeat (3) @(negedge MCLK);
    check("bus off red", 0, tr[0]);
  endtask
  // lit lamp must be alone and step through the running order
  task automatic running_order();
    int bad = 0, wraps = 0, o = 0, p = -1;
    ctl = 16'h4400;
    repeat (3) @(negedge MCLK);
    repeat (80) begin
      @(negedge MCLK);
      if ($countones(lamps) != 1) bad++;
      for (int k = 0; k < NL; k++) if (lamps[k] === 1'b1)
        o = (k < 2) ? k : (k < 2 + CH) ? 2 * k - 2 : 2 * (k - CH) - 1;
      if (p >= 0 && o != p && o != (p + 1) % NL) bad++;
      if (p == NL - 1 && o == 0) wraps++;
      p = o;
    end
    check("running faults", 0, bad);
    check("running wrap", 1, 32'(wraps > 0));
  endtask
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    RESET_N = 1'b0;
    ctl = '0;
    {msg, efr, epas, ovr, boff} = '0;
    repeat (12) @(negedge MCLK);
    RESET_N = 1'b1;
    run_case(16'h0000, 0, 16, 0, 0);
    run_case(16'h4000, 1, 0, 0, 0);
    run_case(16'h6000, 16, 16, 16, 0);
    run_case(16'h5000, 16, 16, 16, 16);
    run_case(16'h4200, 1, 0, 8, 0);
    run_case(16'h8100, 8, 8, 8, 8);
    run_case(16'h8080, 8, 8, 16, 16);
    run_case(16'h8040, 0, 1, 0, 16);
    run_case(16'h8020, 0, 1, 0, 8);
    run_case(16'h8010, 1, 0, 0, 0);
    run_case(16'h8008, 8, 0, 0, 0);
    run_case(16'h8004, 16, 0, 0, 0);
    flash_events();
    passive_channel();
    overrun_hold();
    running_order();
    check("mixed colour", 0, mixed);
    complete_run();
  end
endmodule  // led_status_indicator_bench
